/* src/lsp_pkg.sv */
// Purpose: Shared constants for the link sequence, poll and duplicate block
// Assumes: One station clock mclk at 20 MHz, synchronous active-high reset
// Notes: Frame kinds and timing counts used by the control and FIFO files
//
// Summary of operation
// - Accepting error-free in-order info frame advances receive state by one.
// - Every individually addressed info and supervisory frame carries the next expected sequence.
// - Receive number is stamped from receive state just before transmission.
// - Individually addressed receive number acknowledges all frames below it.
// - Group or global addressed frames carry receive number zero.
// - Group or global received numbers acknowledge nothing.
// - Shared bit is poll in commands, final in responses.
// - Poll at one asks the addressed station for a final response.
// - At most one poll outstanding per direction on the connection.
// - New poll waits for a final response from the peer.
// - Poll may be resent after the poll timer expires.
// - Received poll queues a final response for first opportunity.
// - Final response to a poll goes out at urgent precedence.
// - Responses with final zero may be sent without any command.
// - Connectionless poll gets final response under the response hold.
// - Station keeps an identification counter for originated datagrams.
// - No identification number reused while still unacknowledged.
// - History of received acknowledged datagram commands is kept.
// - Entry holds addresses, number, check value, octet count, receive count.
// - Sequence numbers use modulus 128, seven bits wide.
// - Receive state stays between zero and modulus minus one.
// - History holds at most 255 entries per sending station; the code keeps 8 entries shared by all senders.

package lsp_pkg;

   // ************************************************************
   // Sequence numbering
   // ************************************************************
   localparam int SEQ_W = 7;
   localparam int SEQ_MOD = 128;
   localparam logic [6:0] SEQ_ZERO = 7'h00;
   localparam logic [6:0] SEQ_ONE = 7'h01;

   // ************************************************************
   // Frame kinds
   // ************************************************************
   localparam int KIND_W = 2;
   localparam logic [1:0] KIND_INFO = 2'h0;
   localparam logic [1:0] KIND_SUP = 2'h1;
   localparam logic [1:0] KIND_DGM = 2'h2;
   localparam logic [1:0] KIND_UNNUM = 2'h3;

   // Queued word: cmd, poll, group, kind
   localparam int QW = 5;
   localparam int Q_CMD = 4;
   localparam int Q_POLL = 3;
   localparam int Q_GROUP = 2;
   localparam int Q_KIND = 0;
   localparam int FIFO_DEPTH = 8;

   // ************************************************************
   // Poll timer
   // ************************************************************
   localparam int CLK_HZ = 20000000;
   localparam int POLL_TIME_MS = 1000;
   localparam int POLL_CYCLES = POLL_TIME_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 32;

   // ************************************************************
   // Datagram numbering and history
   // ************************************************************
   localparam int ID_W = 8;
   localparam int ID_NUM = 256;
   localparam int ADDR_W = 8;
   localparam int FCS_W = 16;
   localparam int OCT_W = 12;
   localparam int CNT_W = 8;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam int HIST_MAX = 255;
   localparam int HIST_DEPTH = 8;
   localparam int HIST_PW = 3;

endpackage : lsp_pkg

/* src/lsp_fifo.sv */
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous reset, depth a power of two
// Notes: in_ready is a flop so it can feed a top-level port directly

module lsp_fifo #(
   parameter int WIDTH = lsp_pkg::QW,
   parameter int DEPTH = lsp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [CW-1:0] count, next_count;
   logic next_in_ready;
   logic push, pop;

   always_comb begin
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_count = count + CW'(push) - CW'(pop);
      // Registered so back-pressure never forms a loop with the source
      next_in_ready = next_count != FULL_CNT;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         in_ready <= next_in_ready;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   assign out_valid = count != '0;
   assign out_data = mem[rptr];

endmodule : lsp_fifo

/* src/lsp_link_ctrl.sv */
// Purpose: Receive state, poll/final exchange and datagram duplicate history
// Assumes: Receive and transmit strobes come from logic on mclk
// Notes: One data link connection; frame formats handled elsewhere

module lsp_link_ctrl #(
   parameter int poll_cycles = lsp_pkg::POLL_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Received frame summary, one-cycle strobe
   input wire logic rx_valid,
   input wire logic rx_fcs_ok,
   input wire logic [1:0] rx_kind,
   input wire logic rx_cmd,
   input wire logic rx_pf,
   input wire logic rx_group,
   input wire logic [6:0] rx_ns,
   input wire logic [6:0] rx_nr,
   input wire logic [7:0] rx_src,
   input wire logic [7:0] rx_dst,
   input wire logic [7:0] rx_id,
   input wire logic [15:0] rx_fcs,
   input wire logic [11:0] rx_octets,
   // Transmit requests into the queue
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [1:0] tx_kind,
   input wire logic tx_cmd,
   input wire logic tx_poll,
   input wire logic tx_group,
   // Frame header toward the transmitter
   output logic out_valid,
   input wire logic out_ready,
   output logic [1:0] out_kind,
   output logic out_cmd,
   output logic out_pf,
   output logic out_group,
   output logic [6:0] out_nr,
   output logic out_urgent,
   output logic out_response_hold,
   output logic [7:0] out_dgm_id,
   // Datagram acknowledgement from the peer
   input wire logic dgm_ack_valid,
   input wire logic [7:0] dgm_ack_id,
   // Status
   output logic [6:0] recv_state,
   output logic ack_valid,
   output logic [6:0] ack_nr,
   output logic poll_pending,
   output logic poll_timeout,
   output logic hist_valid,
   output logic hist_hit,
   output logic [7:0] hist_count
);

   // ************************************************************
   // Queue of transmit requests
   // ************************************************************
   logic f_valid, f_ready;
   logic [lsp_pkg::QW-1:0] f_data;

   lsp_fifo #(.WIDTH(lsp_pkg::QW), .DEPTH(lsp_pkg::FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_cmd, tx_poll, tx_group, tx_kind}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // ************************************************************
   // Link state
   // ************************************************************
   logic [lsp_pkg::TMR_W-1:0] ptmr, next_ptmr;
   logic [lsp_pkg::ID_NUM-1:0] id_busy, next_id_busy;
   logic [6:0] next_recv_state, next_out_nr, next_ack_nr;
   logic [7:0] dgm_id, next_dgm_id, next_out_dgm_id;
   logic [1:0] next_out_kind;
   logic final_pend, next_final_pend, final_hold, next_final_hold;
   logic next_out_valid, next_out_cmd, next_out_pf, next_out_group;
   logic next_out_urgent, next_out_response_hold;
   logic next_ack_valid, next_poll_pending, next_poll_timeout;
   logic rx_ok, load, head_pf, head_block, take_final, take_head, launch_poll;

   always_comb begin
      rx_ok = rx_valid & rx_fcs_ok;
      load = ~out_valid | out_ready;
      // Group frames never carry a poll
      head_pf = f_data[lsp_pkg::Q_CMD] & f_data[lsp_pkg::Q_POLL]
         & ~f_data[lsp_pkg::Q_GROUP];
      head_block = (head_pf & poll_pending)
         | (f_data[1:0] == lsp_pkg::KIND_DGM & id_busy[dgm_id]);
      take_final = load & final_pend;
      take_head = load & ~final_pend & f_valid & ~head_block;
      f_ready = take_head;
      launch_poll = take_head & head_pf;

      next_recv_state = recv_state;
      if (rx_ok && rx_kind == lsp_pkg::KIND_INFO && !rx_group
            && rx_ns == recv_state) begin
         // 7-bit add wraps 127 to 0
         next_recv_state = recv_state + lsp_pkg::SEQ_ONE;
      end

      // Only individually addressed numbered frames acknowledge
      next_ack_valid = rx_ok & ~rx_group
         & (rx_kind == lsp_pkg::KIND_INFO | rx_kind == lsp_pkg::KIND_SUP);
      next_ack_nr = next_ack_valid ? rx_nr : ack_nr;

      next_poll_pending = poll_pending;
      next_poll_timeout = 1'b0;
      next_ptmr = ptmr;
      if (rx_ok && !rx_cmd && rx_pf && !rx_group) begin
         next_poll_pending = 1'b0;
      end else if (poll_pending) begin
         next_ptmr = ptmr - 1'b1;
         if (ptmr == lsp_pkg::TMR_W'(1)) begin
            // Expiry frees the slot so the poll may be resent
            next_poll_pending = 1'b0;
            next_poll_timeout = 1'b1;
         end
      end
      if (launch_poll) begin
         next_poll_pending = 1'b1;
         next_ptmr = lsp_pkg::TMR_W'(poll_cycles);
      end

      next_final_pend = final_pend & ~take_final;
      next_final_hold = final_hold;
      // New poll beats the clear of the previous one
      if (rx_ok && rx_cmd && rx_pf && !rx_group) begin
         next_final_pend = 1'b1;
         next_final_hold = rx_kind == lsp_pkg::KIND_DGM;
      end

      next_id_busy = id_busy;
      next_dgm_id = dgm_id;
      if (dgm_ack_valid) begin
         next_id_busy[dgm_ack_id] = 1'b0;
      end
      if (take_head && f_data[1:0] == lsp_pkg::KIND_DGM) begin
         next_id_busy[dgm_id] = 1'b1;
         next_dgm_id = dgm_id + 8'h01;
      end

      next_out_valid = out_valid & ~out_ready;
      next_out_kind = out_kind;
      next_out_cmd = out_cmd;
      next_out_pf = out_pf;
      next_out_group = out_group;
      next_out_nr = out_nr;
      next_out_urgent = out_urgent;
      next_out_response_hold = out_response_hold;
      next_out_dgm_id = out_dgm_id;
      if (take_final) begin
         next_out_valid = 1'b1;
         next_out_kind = final_hold ? lsp_pkg::KIND_DGM : lsp_pkg::KIND_SUP;
         next_out_cmd = 1'b0;
         next_out_pf = 1'b1;
         next_out_group = 1'b0;
         next_out_nr = next_recv_state;
         next_out_urgent = 1'b1;
         next_out_response_hold = final_hold;
         next_out_dgm_id = out_dgm_id;
      end else if (take_head) begin
         next_out_valid = 1'b1;
         next_out_kind = f_data[1:0];
         next_out_cmd = f_data[lsp_pkg::Q_CMD];
         // Queued responses always carry final zero
         next_out_pf = head_pf;
         next_out_group = f_data[lsp_pkg::Q_GROUP];
         next_out_nr = f_data[lsp_pkg::Q_GROUP] ? lsp_pkg::SEQ_ZERO
            : next_recv_state;
         next_out_urgent = 1'b0;
         next_out_response_hold = 1'b0;
         next_out_dgm_id = dgm_id;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         recv_state <= lsp_pkg::SEQ_ZERO;
         ack_valid <= 1'b0;
         ack_nr <= lsp_pkg::SEQ_ZERO;
         poll_pending <= 1'b0;
         poll_timeout <= 1'b0;
         ptmr <= '0;
         final_pend <= 1'b0;
         final_hold <= 1'b0;
         id_busy <= '0;
         dgm_id <= 8'h00;
         out_valid <= 1'b0;
         out_kind <= lsp_pkg::KIND_INFO;
         out_cmd <= 1'b0;
         out_pf <= 1'b0;
         out_group <= 1'b0;
         out_nr <= lsp_pkg::SEQ_ZERO;
         out_urgent <= 1'b0;
         out_response_hold <= 1'b0;
         out_dgm_id <= 8'h00;
      end else begin
         recv_state <= next_recv_state;
         ack_valid <= next_ack_valid;
         ack_nr <= next_ack_nr;
         poll_pending <= next_poll_pending;
         poll_timeout <= next_poll_timeout;
         ptmr <= next_ptmr;
         final_pend <= next_final_pend;
         final_hold <= next_final_hold;
         id_busy <= next_id_busy;
         dgm_id <= next_dgm_id;
         out_valid <= next_out_valid;
         out_kind <= next_out_kind;
         out_cmd <= next_out_cmd;
         out_pf <= next_out_pf;
         out_group <= next_out_group;
         out_nr <= next_out_nr;
         out_urgent <= next_out_urgent;
         out_response_hold <= next_out_response_hold;
         out_dgm_id <= next_out_dgm_id;
      end
   end

   // ************************************************************
   // Duplicate history
   // ************************************************************
   logic [7:0] h_src [lsp_pkg::HIST_DEPTH];
   logic [7:0] h_dst [lsp_pkg::HIST_DEPTH];
   logic [7:0] h_id [lsp_pkg::HIST_DEPTH];
   logic [15:0] h_fcs [lsp_pkg::HIST_DEPTH];
   logic [11:0] h_oct [lsp_pkg::HIST_DEPTH];
   logic [7:0] h_cnt [lsp_pkg::HIST_DEPTH];
   logic [lsp_pkg::HIST_DEPTH-1:0] h_vld, h_match;
   logic [lsp_pkg::HIST_PW-1:0] h_wptr, next_h_wptr, h_sel;
   logic h_rx, h_any, next_hist_valid, next_hist_hit;
   logic [7:0] next_hist_count;

   // Match on sender and number; the verdict itself is left to software
   for (genvar i = 0; i < lsp_pkg::HIST_DEPTH; i++) begin : g_match
      assign h_match[i] = h_vld[i] & h_src[i] == rx_src & h_id[i] == rx_id;
   end

   always_comb begin
      h_rx = rx_ok & rx_cmd & rx_kind == lsp_pkg::KIND_DGM;
      h_any = |h_match;
      h_sel = '0;
      for (int k = lsp_pkg::HIST_DEPTH - 1; k >= 0; k--) begin
         if (h_match[k]) begin
            h_sel = lsp_pkg::HIST_PW'(k);
         end
      end
      next_h_wptr = (h_rx && !h_any) ? h_wptr + 1'b1 : h_wptr;
      next_hist_valid = h_rx;
      next_hist_hit = h_rx ? h_any : hist_hit;
      next_hist_count = hist_count;
      if (h_rx) begin
         next_hist_count = !h_any ? lsp_pkg::CNT_ONE
            : (h_cnt[h_sel] == lsp_pkg::CNT_MAX) ? lsp_pkg::CNT_MAX
            : h_cnt[h_sel] + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         h_vld <= '0;
         h_wptr <= '0;
         hist_valid <= 1'b0;
         hist_hit <= 1'b0;
         hist_count <= 8'h00;
      end else begin
         h_wptr <= next_h_wptr;
         hist_valid <= next_hist_valid;
         hist_hit <= next_hist_hit;
         hist_count <= next_hist_count;
         if (h_rx && !h_any) begin
            h_vld[h_wptr] <= 1'b1;
         end
      end
   end

   // Oldest entry is overwritten round-robin
   always_ff @(posedge mclk) begin
      if (h_rx && h_any) begin
         h_cnt[h_sel] <= next_hist_count;
      end else if (h_rx) begin
         h_src[h_wptr] <= rx_src;
         h_dst[h_wptr] <= rx_dst;
         h_id[h_wptr] <= rx_id;
         h_fcs[h_wptr] <= rx_fcs;
         h_oct[h_wptr] <= rx_octets;
         h_cnt[h_wptr] <= next_hist_count;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_good_info;
      rx_ok && rx_kind == lsp_pkg::KIND_INFO && !rx_group
         && rx_ns == recv_state;
   endsequence
   sequence s_poll_in;
      rx_ok && rx_cmd && rx_pf && !rx_group;
   endsequence

   rs_advance_a: assert property (s_good_info |=>
      recv_state == 7'($past(recv_state) + 7'h01))
      else $error("receive state did not advance");
   rs_hold_a: assert property (!(rx_ok && !rx_group
      && rx_kind == lsp_pkg::KIND_INFO && rx_ns == recv_state) |=>
      $stable(recv_state)) else $error("receive state moved");
   rs_wrap_a: assert property (s_good_info and recv_state == 7'h7f
      |=> recv_state == 7'h00) else $error("receive state did not wrap");
   group_zero_a: assert property ($rose(out_valid) && out_group |->
      out_nr == 7'h00) else $error("group frame with nonzero number");
   nr_stamp_a: assert property ($rose(out_valid) && !out_group
      && out_kind != lsp_pkg::KIND_DGM |-> out_nr == recv_state)
      else $error("receive number not current");
   one_poll_a: assert property (poll_pending && !poll_timeout
      |-> !launch_poll) else $error("second poll launched");
   final_queue_a: assert property (s_poll_in ##1 !out_valid
      |=> out_valid && out_pf && out_urgent)
      else $error("final response not queued");
   tmr_restart_a: assert property (launch_poll |=>
      ptmr == lsp_pkg::TMR_W'(poll_cycles) && poll_pending)
      else $error("poll timer not restarted");
   id_unique_a: assert property (take_head
      && f_data[1:0] == lsp_pkg::KIND_DGM |-> !id_busy[dgm_id])
      else $error("datagram number reused");
   grp_ack_a: assert property (rx_valid && rx_group |=> !ack_valid)
      else $error("group frame acknowledged");

endmodule : lsp_link_ctrl

/* verif/lsp_peer_model.sv */
// Purpose: Peer station side that takes frame headers from the block
// Assumes: Header valid is held by the block until ready is seen
// Notes: slow holds off ready for four cycles before each acceptance

module lsp_peer_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Header from the block
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [1:0] out_kind,
   input wire logic out_cmd,
   input wire logic out_pf,
   input wire logic out_urgent,
   input wire logic out_response_hold,
   input wire logic [6:0] out_nr,
   input wire logic [7:0] out_dgm_id,
   input wire logic out_group,
   // Pacing and capture
   input wire logic slow,
   output logic [21:0] got_hdr,
   output logic [7:0] got_count
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] wait_cnt;

   // Ready is a flop so acceptance never races the block's own edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_ready <= 1'b0;
         wait_cnt <= 2'h0;
         got_count <= 8'h00;
         got_hdr <= 22'h00_0000;
      end else if (out_ready) begin
         out_ready <= 1'b0;
         wait_cnt <= 2'h0;
         if (out_valid) begin
            // Poll/final read as sent, with the receive number
            got_hdr <= {out_group, out_kind, out_cmd, out_pf, out_urgent,
               out_response_hold, out_nr, out_dgm_id};
            got_count <= got_count + 8'h01;
         end
      end else if (out_valid) begin
         wait_cnt <= wait_cnt + 2'h1;
         out_ready <= !slow || (wait_cnt == 2'h3);
      end
   end

endmodule : lsp_peer_model

/* verif/lsp_link_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the link sequence and poll control
// Assumes: Poll timer shortened to 20 cycles
// Notes: The queue is filled behind a held poll and drained in order

module lsp_link_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int POLL = 20;
   logic mclk, rst, rx_valid, rx_fcs_ok, rx_cmd, rx_pf, rx_group;
   logic [1:0] rx_kind, tx_kind, out_kind;
   logic [6:0] rx_ns, rx_nr, out_nr, recv_state, ack_nr, vr;
   logic [7:0] rx_src, rx_dst, rx_id, out_dgm_id, dgm_ack_id, hist_count;
   logic [15:0] rx_fcs;
   logic [11:0] rx_octets;
   logic tx_valid, tx_ready, tx_cmd, tx_poll, tx_group, out_valid;
   logic out_ready, out_cmd, out_pf, out_group, out_urgent;
   logic out_response_hold, dgm_ack_valid, ack_valid, poll_pending;
   logic poll_timeout, hist_valid, hist_hit, slow;
   logic [21:0] got_hdr;
   logic [7:0] got_count, n0, c0, id0;
   int failures, checks_done, i, n;

   lsp_link_ctrl #(.poll_cycles(POLL)) u_lsp_link_ctrl (.*);
   lsp_peer_model u_lsp_peer_model (.*);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic chk_val(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic rx_put(input logic [1:0] k, input logic c, p, g, ok,
         input logic [6:0] ns, nr, input logic [7:0] src, id);
      @(posedge mclk);
      rx_valid <= 1'b1;
      {rx_kind, rx_cmd, rx_pf, rx_group, rx_fcs_ok, rx_ns, rx_nr} <=
         {k, c, p, g, ok, ns, nr};
      {rx_src, rx_id, rx_dst, rx_fcs, rx_octets} <=
         {src, id, id, src, id, 4'h0, src};
   endtask : rx_put

   // Lowers valid at the taking edge, then lets outputs settle
   task automatic rx_end();
      @(posedge mclk);
      rx_valid <= 1'b0;
      #1;
   endtask : rx_end

   task automatic tx_put(input logic [1:0] k, input logic c, p, g);
      @(posedge mclk);
      tx_valid <= 1'b1;
      {tx_kind, tx_cmd, tx_poll, tx_group} <= {k, c, p, g};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (tx_ready !== 1'b1 && n < 50);
      tx_valid <= 1'b0;
      chk_val("tx taken", 16'h0001, n < 50);
   endtask : tx_put

   task automatic wait_hdr();
      n0 = got_count;
      n = 0;
      while (got_count === n0 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      #1;
      chk_val("header taken", 16'h0001, n < 60);
   endtask : wait_hdr

   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("BAD watchdog expected finish seen hang");
      report_and_stop();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      rst = 1'b1;
      {rx_valid, rx_fcs_ok, rx_cmd, rx_pf, rx_group, rx_kind} = '0;
      {rx_ns, rx_nr, rx_src, rx_dst, rx_id, rx_fcs, rx_octets} = '0;
      {tx_valid, tx_kind, tx_cmd, tx_poll, tx_group, slow} = '0;
      {dgm_ack_valid, dgm_ack_id} = '0;
      failures = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk_val("recv_state", 16'h0000, recv_state);
      chk_val("tx_ready", 16'h0001, tx_ready);
      chk_val("poll_pending", 16'h0000, poll_pending);
      // Good, bad check, out of order and group frames
      vr = 7'h00;
      rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b0, 1'b1, vr, 7'h05,
         8'h11, 8'h00);
      rx_end();
      vr = vr + 7'h01;
      chk_val("recv_state", vr, recv_state);
      chk_val("ack_valid", 16'h0001, ack_valid);
      chk_val("ack_nr", 16'h0005, ack_nr);
      rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b0, 1'b0, vr, 7'h06,
         8'h11, 8'h00);
      rx_end();
      chk_val("recv_state", vr, recv_state);
      chk_val("ack_valid", 16'h0000, ack_valid);
      rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b0, 1'b1, vr + 7'h03,
         7'h06, 8'h11, 8'h00);
      rx_end();
      chk_val("recv_state", vr, recv_state);
      rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b1, 1'b1, vr, 7'h09,
         8'h11, 8'h00);
      rx_end();
      chk_val("recv_state", vr, recv_state);
      chk_val("ack_valid", 16'h0000, ack_valid);
      // Back to back through the wrap point
      for (i = 0; i < 127; i++) begin
         rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b0, 1'b1,
            vr + 7'(i), 7'h00, 8'h11, 8'h00);
      end
      rx_end();
      vr = 7'h00;
      chk_val("recv_state wrap", vr, recv_state);
      rx_put(lsp_pkg::KIND_INFO, 1'b0, 1'b0, 1'b0, 1'b1, vr, 7'h00,
         8'h11, 8'h00);
      rx_end();
      vr = 7'h01;
      tx_put(lsp_pkg::KIND_INFO, 1'b1, 1'b0, 1'b0);
      wait_hdr();
      chk_val("stamped nr", vr, got_hdr[14:8]);
      tx_put(lsp_pkg::KIND_INFO, 1'b1, 1'b1, 1'b1);
      wait_hdr();
      chk_val("group nr", 16'h0000, got_hdr[14:8]);
      chk_val("group pf", 16'h0000, got_hdr[17]);
      chk_val("group flag", 16'h0001, got_hdr[21]);
      tx_put(lsp_pkg::KIND_SUP, 1'b0, 1'b0, 1'b0);
      wait_hdr();
      chk_val("free response", 16'h0000, got_hdr[18:17]);
      // Received polls get an urgent final response
      rx_put(lsp_pkg::KIND_INFO, 1'b1, 1'b1, 1'b0, 1'b1, vr, 7'h00,
         8'h11, 8'h00);
      rx_end();
      vr = vr + 7'h01;
      wait_hdr();
      chk_val("final kind", lsp_pkg::KIND_SUP, got_hdr[20:19]);
      chk_val("final cmd pf", 16'h0001, got_hdr[18:17]);
      chk_val("final urgent", 16'h0001, got_hdr[16]);
      chk_val("final nr", vr, got_hdr[14:8]);
      rx_put(lsp_pkg::KIND_DGM, 1'b1, 1'b1, 1'b0, 1'b1, 7'h00, 7'h00,
         8'h40, 8'h01);
      rx_end();
      wait_hdr();
      chk_val("dgram final kind", lsp_pkg::KIND_DGM, got_hdr[20:19]);
      chk_val("response hold", 16'h0001, got_hdr[15]);
      // One poll outstanding, slow peer
      slow <= 1'b1;
      tx_put(lsp_pkg::KIND_SUP, 1'b1, 1'b1, 1'b0);
      wait_hdr();
      chk_val("poll pf", 16'h0001, got_hdr[17]);
      chk_val("poll_pending", 16'h0001, poll_pending);
      c0 = got_count;
      tx_put(lsp_pkg::KIND_SUP, 1'b1, 1'b1, 1'b0);
      repeat (10) @(posedge mclk);
      #1;
      chk_val("second poll held", c0, got_count);
      rx_put(lsp_pkg::KIND_SUP, 1'b0, 1'b1, 1'b0, 1'b1, 7'h00, 7'h00,
         8'h11, 8'h00);
      rx_end();
      wait_hdr();
      chk_val("second poll pf", 16'h0001, got_hdr[17]);
      n = 0;
      while (poll_timeout !== 1'b1 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      chk_val("poll timer span", 16'h0001, n >= 10 && n <= 21);
      #1;
      chk_val("poll_pending", 16'h0000, poll_pending);
      slow <= 1'b0;
      // Datagram numbering
      tx_put(lsp_pkg::KIND_DGM, 1'b1, 1'b0, 1'b0);
      wait_hdr();
      id0 = got_hdr[7:0];
      tx_put(lsp_pkg::KIND_DGM, 1'b1, 1'b0, 1'b0);
      wait_hdr();
      chk_val("next id", id0 + 8'h01, got_hdr[7:0]);
      @(posedge mclk);
      dgm_ack_valid <= 1'b1;
      dgm_ack_id <= id0;
      @(posedge mclk);
      dgm_ack_valid <= 1'b0;
      tx_put(lsp_pkg::KIND_DGM, 1'b1, 1'b0, 1'b0);
      wait_hdr();
      chk_val("third id", id0 + 8'h02, got_hdr[7:0]);
      // Duplicate history: new, repeat, other sender
      for (i = 0; i < 3; i++) begin
         rx_put(lsp_pkg::KIND_DGM, 1'b1, 1'b0, 1'b0, 1'b1, 7'h00, 7'h00,
            (i == 2) ? 8'h22 : 8'h21, 8'h5a);
         rx_end();
         chk_val("hist_valid", 16'h0001, hist_valid);
         chk_val("hist_hit", 16'(i == 1), hist_hit);
         chk_val("hist_count", 16'(i == 1) + 16'h0001, hist_count);
      end
      // First poll launches, the rest fill the queue behind it
      n = 0;
      @(posedge mclk);
      tx_valid <= 1'b1;
      {tx_kind, tx_cmd, tx_poll, tx_group} <= {lsp_pkg::KIND_INFO, 3'h6};
      repeat (12) begin
         @(posedge mclk);
         if (tx_ready === 1'b1) begin
            n++;
            tx_kind <= {1'b0, n[0]};
         end
      end
      tx_valid <= 1'b0;
      chk_val("queue fill", 16'(lsp_pkg::FIFO_DEPTH + 1), 16'(n));
      c0 = got_count;
      // Each timeout frees the next poll, kinds come out in order
      for (i = 1; i <= lsp_pkg::FIFO_DEPTH; i++) begin
         wait_hdr();
         chk_val("queue order", 16'(i % 2), got_hdr[20:19]);
      end
      chk_val("queue drained", c0 + 8'h08, got_count);
      chk_val("queue ready", 16'h0001, tx_ready);
      report_and_stop();
   end

endmodule : lsp_link_ctrl_tb_top
